// ---- hw/twmrs_pkg.sv ----
/*
 * Shared constants and types of the two-wire master receive sequencer.
 * Assumes a 20 MHz system clock; the bus bit rate is a fixed constant.
 */
package twmrs_pkg;
   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int CLK_MHZ = 20;
   localparam int QUARTER_BIT_NS = 2500;
   localparam int QUARTER_CYC = (QUARTER_BIT_NS * CLK_MHZ + 999) / 1000;
   localparam int TMR_W = 8;

   // ------------------------------------------------------------
   // Status codes, upper five bits of the status byte
   // ------------------------------------------------------------
   localparam logic [4:0] ST_BUS_ERR = 5'h00;
   localparam logic [4:0] ST_START = 5'h01;
   localparam logic [4:0] ST_REP_START = 5'h02;
   localparam logic [4:0] ST_TX_ADDR_ACK = 5'h03;
   localparam logic [4:0] ST_TX_ADDR_NACK = 5'h04;
   localparam logic [4:0] ST_TX_BYTE_ACK = 5'h05;
   localparam logic [4:0] ST_TX_BYTE_NACK = 5'h06;
   localparam logic [4:0] ST_ARB_LOST = 5'h07;
   localparam logic [4:0] ST_RX_ADDR_ACK = 5'h08;
   localparam logic [4:0] ST_RX_ADDR_NACK = 5'h09;
   localparam logic [4:0] ST_RX_BYTE_ACK = 5'h0A;
   localparam logic [4:0] ST_RX_BYTE_NACK = 5'h0B;
   localparam logic [4:0] ST_NO_INFO = 5'h1F;
   localparam logic [2:0] STATUS_PAD = 3'h0;
   localparam logic [7:0] RESET_BYTE = 8'h00;
   localparam logic [7:0] IDLE_RX_BYTE = 8'hFF;
   localparam int DIR_BIT = 0;
   localparam logic [3:0] ACK_SLOT = 4'h8;

   // ------------------------------------------------------------
   // Types
   // ------------------------------------------------------------
   typedef enum logic [4:0] {
      CMD_START = 5'b00001,
      CMD_STOP = 5'b00010,
      CMD_WRITE = 5'b00100,
      CMD_READ = 5'b01000,
      CMD_RELEASE = 5'b10000
   } twmrs_cmd_t;

   typedef enum logic [3:0] {
      S_IDLE = 4'b0001,
      S_WAIT_FREE = 4'b0010,
      S_BUSY = 4'b0100,
      S_HOLD = 4'b1000
   } twmrs_state_t;

   typedef enum logic [3:0] {
      E_IDLE = 4'b0001,
      E_START = 4'b0010,
      E_STOP = 4'b0100,
      E_BIT = 4'b1000
   } twmrs_eng_t;
endpackage

// ---- hw/twmrs_link_if.sv ----
/*
 * Command and result link between sequencer and bit engine.
 * Assumes both ends share one clock.
 */
`timescale 1ns/100ps
interface twmrs_link_if;
   import twmrs_pkg::*;
   twmrs_cmd_t cmd;
   logic cmdValid;
   logic [7:0] txByte;
   logic ackOut;
   logic done;
   logic [7:0] rxByte;
   logic rxAck;
   logic arbLost;
   logic busErr;
   logic busBusy;
   modport engine (input cmd, cmdValid, txByte, ackOut,
      output done, rxByte, rxAck, arbLost, busErr, busBusy);
   modport seq (output cmd, cmdValid, txByte, ackOut,
      input done, rxByte, rxAck, arbLost, busErr, busBusy);
endinterface // twmrs_link_if

// ---- hw/twmrs_bit_engine.sv ----
/*
 * Bit engine: START, STOP, nine-bit byte slots, bus watch.
 * Assumes open-drain lines resolved outside; pins are asynchronous.
 */
`timescale 1ns/100ps
module twmrs_bit_engine (
   input wire logic clk,
   input wire logic reset,
   input wire logic sclIn,
   input wire logic sdaIn,
   output logic sclLow,
   output logic sdaLow,
   twmrs_link_if.engine lnk
);
   import twmrs_pkg::*;

   // ------------------------------------------------------------
   // Pin synchronisers and bus watch
   // ------------------------------------------------------------
   logic [2:0] sclSync_r, sdaSync_r;
   logic sclF_r, sdaF_r, sclPrev_r, sdaPrev_r, busy_r;
   wire startDet = sclF_r && sclPrev_r && sdaPrev_r && !sdaF_r;
   wire stopDet = sclF_r && sclPrev_r && !sdaPrev_r && sdaF_r;

   always_ff @(posedge clk) begin
      if (reset) begin
         sclSync_r <= 3'h7;
         sdaSync_r <= 3'h7;
         sclF_r <= 1'b1;
         sdaF_r <= 1'b1;
         sclPrev_r <= 1'b1;
         sdaPrev_r <= 1'b1;
         busy_r <= 1'b0;
      end else begin
         sclSync_r <= {sclSync_r[1:0], sclIn};
         sdaSync_r <= {sdaSync_r[1:0], sdaIn};
         if (sclSync_r[1] == sclSync_r[2]) sclF_r <= sclSync_r[2];
         if (sdaSync_r[1] == sdaSync_r[2]) sdaF_r <= sdaSync_r[2];
         sclPrev_r <= sclF_r;
         sdaPrev_r <= sdaF_r;
         if (startDet) busy_r <= 1'b1;
         else if (stopDet) busy_r <= 1'b0;
      end
   end
   assign lnk.busBusy = busy_r;

   // ------------------------------------------------------------
   // Sequencing
   // ------------------------------------------------------------
   twmrs_eng_t state_r;
   logic [TMR_W-1:0] timer_r;
   logic [1:0] phase_r;
   logic [3:0] bitCnt_r;
   logic [7:0] shift_r, rx_r;
   logic isRead_r, ack_r, done_r, rxAck_r, arb_r, err_r;
   wire atEnd = (timer_r == TMR_W'(QUARTER_CYC - 1));
   wire tick = atEnd && (phase_r != 2'd1 || sclF_r);
   wire ackSlot = (bitCnt_r == ACK_SLOT);
   wire ackBitOut = isRead_r ? !ack_r : 1'b1;
   wire txBit = ackSlot ? ackBitOut : shift_r[7];
   wire nextTx = (bitCnt_r == ACK_SLOT - 4'd1) ? ackBitOut : shift_r[6];
   wire driven = isRead_r ? ackSlot : !ackSlot;
   wire lost = driven && txBit && !sdaF_r;
   wire illegal = (state_r == E_BIT) && (startDet || stopDet);

   always_ff @(posedge clk) begin
      if (reset) begin
         state_r <= E_IDLE;
         timer_r <= '0;
         phase_r <= 2'd0;
         bitCnt_r <= 4'd0;
         shift_r <= RESET_BYTE;
         rx_r <= RESET_BYTE;
         isRead_r <= 1'b0;
         ack_r <= 1'b0;
         done_r <= 1'b0;
         rxAck_r <= 1'b0;
         arb_r <= 1'b0;
         err_r <= 1'b0;
         sclLow <= 1'b0;
         sdaLow <= 1'b0;
      end else begin
         done_r <= 1'b0;
         timer_r <= tick ? '0 : (atEnd ? timer_r : timer_r + TMR_W'(1));
         if (state_r == E_IDLE) begin
            timer_r <= '0;
            phase_r <= 2'd0;
            bitCnt_r <= 4'd0;
            if (lnk.cmdValid) begin
               arb_r <= 1'b0;
               err_r <= 1'b0;
               isRead_r <= (lnk.cmd == CMD_READ);
               ack_r <= lnk.ackOut;
               shift_r <= (lnk.cmd == CMD_READ) ? IDLE_RX_BYTE : lnk.txByte;
               case (lnk.cmd)
                  CMD_START: begin
                     state_r <= E_START;
                     sdaLow <= 1'b0;
                  end
                  CMD_STOP: begin
                     state_r <= E_STOP;
                     sdaLow <= 1'b1;
                  end
                  CMD_WRITE: begin
                     state_r <= E_BIT;
                     sdaLow <= !lnk.txByte[7];
                  end
                  CMD_READ: begin
                     state_r <= E_BIT;
                     sdaLow <= 1'b0;
                  end
                  default: begin
                     sclLow <= 1'b0;
                     sdaLow <= 1'b0;
                     done_r <= 1'b1;
                  end
               endcase
            end
         end else if (illegal) begin
            sclLow <= 1'b0;
            sdaLow <= 1'b0;
            err_r <= 1'b1;
            done_r <= 1'b1;
            state_r <= E_IDLE;
         end else if (tick) begin
            phase_r <= phase_r + 2'd1;
            case (state_r)
               E_START: begin
                  if (phase_r == 2'd0) sclLow <= 1'b0;
                  if (phase_r == 2'd1) sdaLow <= 1'b1;
                  if (phase_r == 2'd2) sclLow <= 1'b1;
                  if (phase_r == 2'd3) begin
                     done_r <= 1'b1;
                     state_r <= E_IDLE;
                  end
               end
               E_STOP: begin
                  if (phase_r == 2'd0) sclLow <= 1'b0;
                  if (phase_r == 2'd1) sdaLow <= 1'b0;
                  if (phase_r == 2'd3) begin
                     done_r <= 1'b1;
                     state_r <= E_IDLE;
                  end
               end
               default: begin
                  if (phase_r == 2'd0) sclLow <= 1'b0;
                  if (phase_r == 2'd1) begin
                     if (ackSlot) rxAck_r <= !sdaF_r;
                     else rx_r <= {rx_r[6:0], sdaF_r};
                     if (lost) begin
                        sclLow <= 1'b0;
                        sdaLow <= 1'b0;
                        arb_r <= 1'b1;
                        done_r <= 1'b1;
                        state_r <= E_IDLE;
                     end
                  end
                  if (phase_r == 2'd2) sclLow <= 1'b1;
                  if (phase_r == 2'd3) begin
                     if (ackSlot) begin
                        done_r <= 1'b1;
                        state_r <= E_IDLE;
                     end else begin
                        bitCnt_r <= bitCnt_r + 4'd1;
                        shift_r <= {shift_r[6:0], 1'b1};
                        sdaLow <= !nextTx;
                     end
                  end
               end
            endcase
         end
      end
   end

   assign lnk.done = done_r;
   assign lnk.rxByte = rx_r;
   assign lnk.rxAck = rxAck_r;
   assign lnk.arbLost = arb_r;
   assign lnk.busErr = err_r;
endmodule // twmrs_bit_engine

// ---- hw/twmrs_sequencer.sv ----
/*
 * Master receive sequencer: control bits, status byte, data byte.
 * Assumes software handshakes on the step flag; pins are open drain.
 */
`timescale 1ns/100ps
// How it works
// - After START report $08; loaded read address then goes out, ack sampled.
// - After repeated START report $10; write address byte switches to transmit.
// - Lost arbitration reports $38 with bus already released; clear without start goes idle.
// - In $38, clear with start set waits for free bus, then START.
// - Acked read address reports $40; clear then receives a data byte.
// - Acknowledge enable at flag clearing picks ACK or NOT ACK after byte.
// - Unacked read address reports $48; only restart, stop, stop-start accepted.
// - Clear with stop only sends STOP and hardware clears stop request.
// - Clear with start and stop sends STOP, then START, clears stop.
// - Byte received with ACK reports $50, byte held in data register.
// - Byte received with NOT ACK reports $58; software chooses the end.
// - Writing one to flag with enable starts a step; flag sets when done, but not after STOP or release.
// - Status reads $F8 while the step flag is clear.
// - Misplaced START or STOP gives $00; stop plus clear releases silently.
module twmrs_sequencer (
   input wire logic clk,
   input wire logic reset,
   input wire logic ctrlWrite,
   input wire logic ctrlStepDone,
   input wire logic ctrlStart,
   input wire logic ctrlStop,
   input wire logic ctrlAckEn,
   input wire logic ctrlEnable,
   input wire logic dataWrite,
   input wire logic [7:0] dataIn,
   output logic stepDoneFlag,
   output logic startRequest,
   output logic stopRequest,
   output logic ackEnable,
   output logic interfaceEnable,
   output logic [7:0] busStatusReg,
   output logic [7:0] shiftDataReg,
   input wire logic sclIn,
   output logic sclOut,
   output logic sclOe,
   input wire logic sdaIn,
   output logic sdaOut,
   output logic sdaOe
);
   import twmrs_pkg::*;

   function automatic logic [7:0] statusByte(input logic [4:0] code);
      statusByte = {code, STATUS_PAD};
   endfunction

   // ------------------------------------------------------------
   // Engine
   // ------------------------------------------------------------
   twmrs_link_if lnk ();
   twmrs_bit_engine engine (
      .clk(clk),
      .reset(reset),
      .sclIn(sclIn),
      .sdaIn(sdaIn),
      .sclLow(sclOe),
      .sdaLow(sdaOe),
      .lnk(lnk)
   );
   assign sclOut = 1'b0;
   assign sdaOut = 1'b0;

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   twmrs_state_t state_r, state_nxt;
   twmrs_cmd_t cmd_r, cmd_nxt;
   logic cmdValid_r, cmdValid_nxt;
   logic flag_r, flag_nxt, staReq_r, stoReq_r, stoReq_nxt, ack_r, en_r;
   logic [4:0] code_r, code_nxt;
   logic [7:0] data_r, data_nxt, status_r;
   logic ownBus_r, ownBus_nxt, readMode_r, readMode_nxt;
   logic addrStep_r, addrStep_nxt, pendStart_r, pendStart_nxt;
   logic ackSent_r, ackSent_nxt;

   // ------------------------------------------------------------
   // Decode
   // ------------------------------------------------------------
   wire clearing = ctrlWrite && ctrlStepDone && ctrlEnable;
   wire inHold = (state_r == S_HOLD);
   wire isErr = (code_r == ST_BUS_ERR);
   wire isArb = (code_r == ST_ARB_LOST);
   wire isAddr = (code_r == ST_START) || (code_r == ST_REP_START);
   wire isRx = (code_r == ST_RX_ADDR_ACK) || (code_r == ST_RX_BYTE_ACK);
   wire isTx = (code_r >= ST_TX_ADDR_ACK) && (code_r <= ST_TX_BYTE_NACK);
   wire anyReply = isArb || isAddr || isRx || isTx ||
      ctrlStart || ctrlStop;
   wire accept = clearing &&
      ((state_r == S_IDLE && ctrlStart) ||
       (inHold && (isErr ? ctrlStop : anyReply)));

   always_comb begin
      state_nxt = state_r;
      cmd_nxt = cmd_r;
      cmdValid_nxt = 1'b0;
      code_nxt = code_r;
      data_nxt = data_r;
      ownBus_nxt = ownBus_r;
      readMode_nxt = readMode_r;
      addrStep_nxt = addrStep_r;
      pendStart_nxt = pendStart_r;
      ackSent_nxt = ackSent_r;
      stoReq_nxt = ctrlWrite ? ctrlStop : stoReq_r;
      flag_nxt = flag_r && !accept;
      if (dataWrite) data_nxt = dataIn;
      case (state_r)
         S_IDLE: begin
            if (accept) state_nxt = S_WAIT_FREE;
         end
         S_WAIT_FREE: begin
            if (!lnk.busBusy || ownBus_r) begin
               cmd_nxt = CMD_START;
               cmdValid_nxt = 1'b1;
               state_nxt = S_BUSY;
            end
         end
         S_HOLD: begin
            if (accept) begin
               cmdValid_nxt = 1'b1;
               state_nxt = S_BUSY;
               addrStep_nxt = 1'b0;
               if (isErr) begin
                  cmd_nxt = CMD_RELEASE;
                  stoReq_nxt = 1'b0;
                  ownBus_nxt = 1'b0;
               end else if (isArb) begin
                  cmdValid_nxt = 1'b0;
                  state_nxt = ctrlStart ? S_WAIT_FREE : S_IDLE;
               end else if (isAddr && !ctrlStop) begin
                  cmd_nxt = CMD_WRITE;
                  addrStep_nxt = 1'b1;
                  readMode_nxt = data_r[DIR_BIT];
               end else if (ctrlStop) begin
                  cmd_nxt = CMD_STOP;
                  pendStart_nxt = ctrlStart;
               end else if (ctrlStart) begin
                  cmd_nxt = CMD_START;
               end else if (isRx) begin
                  cmd_nxt = CMD_READ;
                  ackSent_nxt = ctrlAckEn;
               end else begin
                  cmd_nxt = CMD_WRITE;
               end
            end
         end
         default: begin
            if (lnk.done) begin
               flag_nxt = 1'b1;
               state_nxt = S_HOLD;
               if (lnk.busErr) begin
                  code_nxt = ST_BUS_ERR;
                  ownBus_nxt = 1'b0;
               end else if (lnk.arbLost) begin
                  code_nxt = ST_ARB_LOST;
                  ownBus_nxt = 1'b0;
               end else if (cmd_r == CMD_START) begin
                  code_nxt = ownBus_r ? ST_REP_START : ST_START;
                  ownBus_nxt = 1'b1;
               end else if (cmd_r == CMD_WRITE && addrStep_r &&
                            readMode_r) begin
                  code_nxt = lnk.rxAck ? ST_RX_ADDR_ACK
                                       : ST_RX_ADDR_NACK;
               end else if (cmd_r == CMD_WRITE && addrStep_r) begin
                  code_nxt = lnk.rxAck ? ST_TX_ADDR_ACK : ST_TX_ADDR_NACK;
               end else if (cmd_r == CMD_WRITE) begin
                  code_nxt = lnk.rxAck ? ST_TX_BYTE_ACK : ST_TX_BYTE_NACK;
               end else if (cmd_r == CMD_READ) begin
                  data_nxt = lnk.rxByte;
                  code_nxt = ackSent_r ? ST_RX_BYTE_ACK
                                       : ST_RX_BYTE_NACK;
               end else begin
                  flag_nxt = flag_r;
                  ownBus_nxt = 1'b0;
                  if (cmd_r == CMD_STOP && !ctrlWrite) stoReq_nxt = 1'b0;
                  state_nxt = pendStart_r ? S_WAIT_FREE : S_IDLE;
                  pendStart_nxt = 1'b0;
               end
            end
         end
      endcase
   end

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (reset) begin
         state_r <= S_IDLE;
         cmd_r <= CMD_RELEASE;
         cmdValid_r <= 1'b0;
         flag_r <= 1'b0;
         staReq_r <= 1'b0;
         stoReq_r <= 1'b0;
         ack_r <= 1'b0;
         en_r <= 1'b0;
         code_r <= ST_NO_INFO;
         data_r <= RESET_BYTE;
         status_r <= statusByte(ST_NO_INFO);
         ownBus_r <= 1'b0;
         readMode_r <= 1'b0;
         addrStep_r <= 1'b0;
         pendStart_r <= 1'b0;
         ackSent_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         cmd_r <= cmd_nxt;
         cmdValid_r <= cmdValid_nxt;
         flag_r <= flag_nxt;
         stoReq_r <= stoReq_nxt;
         if (ctrlWrite) begin
            staReq_r <= ctrlStart;
            ack_r <= ctrlAckEn;
            en_r <= ctrlEnable;
         end
         code_r <= code_nxt;
         data_r <= data_nxt;
         status_r <= statusByte(flag_nxt ? code_nxt
                                         : ST_NO_INFO);
         ownBus_r <= ownBus_nxt;
         readMode_r <= readMode_nxt;
         addrStep_r <= addrStep_nxt;
         pendStart_r <= pendStart_nxt;
         ackSent_r <= ackSent_nxt;
      end
   end

   assign lnk.cmd = cmd_r;
   assign lnk.cmdValid = cmdValid_r;
   assign lnk.txByte = data_r;
   assign lnk.ackOut = ackSent_r;
   assign stepDoneFlag = flag_r;
   assign startRequest = staReq_r;
   assign stopRequest = stoReq_r;
   assign ackEnable = ack_r;
   assign interfaceEnable = en_r;
   assign busStatusReg = status_r;
   assign shiftDataReg = data_r;
endmodule // twmrs_sequencer

// ---- verif/twmrs_sva.sv ----
/* Assertion checker of the sequencer control and status ports.
   Assumes one clock and a synchronous active-high reset. */
`timescale 1ns/100ps
module twmrs_sva (
   input wire logic clk,
   input wire logic reset,
   input wire logic ctrlWrite,
   input wire logic ctrlStepDone,
   input wire logic ctrlStart,
   input wire logic ctrlStop,
   input wire logic ctrlEnable,
   input wire logic dataWrite,
   input wire logic stepDoneFlag,
   input wire logic stopRequest,
   input wire logic [7:0] busStatusReg,
   input wire logic [7:0] shiftDataReg,
   input wire logic sclOe,
   input wire logic sdaOe
);
   // ----------
   // Properties
   // ----------
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   wire clr = ctrlWrite && ctrlStepDone && ctrlEnable && stepDoneFlag;
   wire bare = clr && !ctrlStart && !ctrlStop;
   property p_noinfo; !stepDoneFlag |-> busStatusReg == 8'hF8; endproperty
   a_noinfo: assert property (p_noinfo) else $error("status not F8");
   property p_low;
      stepDoneFlag |-> busStatusReg[2:0] == 3'h0 && busStatusReg != 8'hF8;
   endproperty
   a_low: assert property (p_low) else $error("status low bits");
   property p_go;
      bare && busStatusReg inside {8'h08, 8'h40, 8'h50} |=> !stepDoneFlag;
   endproperty
   a_go: assert property (p_go) else $error("step not started");
   property p_refuse;
      bare && busStatusReg inside {8'h48, 8'h58} |=> stepDoneFlag;
   endproperty
   a_refuse: assert property (p_refuse) else $error("bad clear taken");
   property p_stop;
      clr && ctrlStop && !ctrlStart && busStatusReg inside {8'h48, 8'h58}
         |=> ##[0:1000] (!stopRequest && !sclOe && !sdaOe);
   endproperty
   a_stop: assert property (p_stop) else $error("stop not done");
   property p_arb;
      stepDoneFlag && busStatusReg == 8'h38 |-> !sclOe && !sdaOe;
   endproperty
   a_arb: assert property (p_arb) else $error("bus not released");
   property p_keep;
      stepDoneFlag && busStatusReg == 8'h50 && !dataWrite && !ctrlWrite
         |=> $stable(shiftDataReg);
   endproperty
   a_keep: assert property (p_keep) else $error("byte lost");
   property p_stand; stepDoneFlag && !ctrlWrite |=> stepDoneFlag; endproperty
   a_stand: assert property (p_stand) else $error("flag dropped");
endmodule // twmrs_sva
bind twmrs_sequencer twmrs_sva twmrs_sva_inst (.clk, .reset, .ctrlWrite,
   .ctrlStepDone, .ctrlStart, .ctrlStop, .ctrlEnable, .dataWrite,
   .stepDoneFlag, .stopRequest, .busStatusReg, .shiftDataReg, .sclOe,
   .sdaOe);

// ---- verif/twmrs_slave_model.sv ----
/* Behavioural two-wire slave: acks its address, sends txData on reads.
   Assumes resolved open-drain levels with pull-ups on both lines. */
`timescale 1ns/100ps
module twmrs_slave_model #(
   parameter logic [6:0] ADDR = 7'h64
) (
   input wire logic scl,
   input wire logic sda,
   input wire logic [7:0] txData,
   output logic sdaLow,
   output logic mstAck
);
   // ------------------------
   // Bit counting and answers
   // ------------------------
   int bitCnt_r = 0;
   logic [7:0] sh_r = 8'h00;
   logic act_r = 1'b0;
   logic adr_r = 1'b0;
   logic rd_r = 1'b0;
   initial sdaLow = 1'b0;
   initial mstAck = 1'b0;
   always @(negedge sda) if (scl) begin
      bitCnt_r = 0;
      adr_r = 1'b1;
      act_r = 1'b1;
   end
   always @(posedge sda) if (scl) begin
      act_r = 1'b0;
      sdaLow = 1'b0;
   end
   always @(posedge scl) if (act_r) begin
      if (bitCnt_r < 8) sh_r = {sh_r[6:0], sda};
      if (bitCnt_r == 8 && rd_r && !adr_r) mstAck = !sda;
      if (bitCnt_r == 8 && rd_r && !adr_r && sda) act_r = 1'b0;
      bitCnt_r++;
   end
   always @(negedge scl) if (act_r) begin
      if (bitCnt_r == 9) begin
         bitCnt_r = 0;
         adr_r = 1'b0;
      end
      if (bitCnt_r == 8 && adr_r) begin
         rd_r = sh_r[0];
         act_r = sh_r[7:1] == ADDR;
      end
      sdaLow = bitCnt_r == 8 ? act_r && !(rd_r && !adr_r)
         : act_r && rd_r && !adr_r && !txData[7 - bitCnt_r];
   end
endmodule // twmrs_slave_model

// ---- verif/twmrs_sequencer_tb.sv ----
/* Self-checking bench of the master receive sequencer.
   Assumes pull-ups on both lines and one slave at address 7'h64. */
`timescale 1ns/100ps
module twmrs_sequencer_tb;
   // -------------
   // Bench signals
   // -------------
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic ctrlWrite = 1'b0;
   logic ctrlStepDone = 1'b0;
   logic ctrlStart = 1'b0;
   logic ctrlStop = 1'b0;
   logic ctrlAckEn = 1'b0;
   logic ctrlEnable = 1'b0;
   logic dataWrite = 1'b0;
   logic [7:0] dataIn = 8'h00;
   logic rivalLow = 1'b0;
   logic [7:0] slvData = 8'h00;
   logic stepDoneFlag, startRequest, stopRequest, ackEnable;
   logic interfaceEnable, sclOut, sclOe, sdaOut, sdaOe, slvLow, mstAck;
   logic [7:0] busStatusReg, shiftDataReg;
   int miscompares = 0;
   int comparisons = 0;
   int cycles = 0;
   wire scl = !sclOe;
   wire sda = !(sdaOe || slvLow || rivalLow);
   twmrs_sequencer twmrs_sequencer_inst (.clk, .reset, .ctrlWrite,
      .ctrlStepDone, .ctrlStart, .ctrlStop, .ctrlAckEn, .ctrlEnable,
      .dataWrite, .dataIn, .stepDoneFlag, .startRequest, .stopRequest,
      .ackEnable, .interfaceEnable, .busStatusReg, .shiftDataReg,
      .sclIn(scl), .sclOut, .sclOe, .sdaIn(sda), .sdaOut, .sdaOe);
   twmrs_slave_model twmrs_slave_model_inst (.scl, .sda, .txData(slvData),
      .sdaLow(slvLow), .mstAck);
   initial forever #25 clk = !clk;
   always @(posedge clk) begin
      cycles++;
      if (cycles == 60000) begin
         miscompares++;
         final_report;
      end
   end
   task automatic check(string name, logic [7:0] seen, logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic ctl(logic start_request, logic stop_request, logic ack);
      @(negedge clk);
      {ctrlWrite, ctrlStepDone, ctrlEnable} = 3'b111;
      {ctrlStart, ctrlStop, ctrlAckEn} = {start_request, stop_request, ack};
      @(negedge clk);
      ctrlWrite = 1'b0;
   endtask
   task automatic load(logic [7:0] b);
      @(negedge clk);
      dataWrite = 1'b1;
      dataIn = b;
      @(negedge clk);
      dataWrite = 1'b0;
   endtask
   task automatic wait_st(logic [7:0] st);
      int n;
      n = 0;
      @(negedge clk);
      while (stepDoneFlag !== 1'b1 && n < 4000) begin
         @(negedge clk);
         n++;
      end
      check("status", busStatusReg, st);
   endtask
   task automatic step(logic start_request, logic stop_request, logic ack, logic [7:0] st);
      ctl(start_request, stop_request, ack);
      wait_st(st);
   endtask
   task automatic end_stop;
      int n;
      n = 0;
      ctl(0, 1, 0);
      while (stopRequest !== 1'b0 && n < 1000) begin
         @(negedge clk);
         n++;
      end
      check("stop bit", stopRequest, 0);
      check("flag", stepDoneFlag, 0);
      check("lines", {scl, sda}, 2'b11);
   endtask
   // ---------
   // Scenarios
   // ---------
   task automatic t_reset;
      check("status", busStatusReg, 8'hF8);
      check("idle", {stepDoneFlag, sclOe, sdaOe, sclOut, sdaOut}, 0);
      $display("test reset done");
   endtask
   task automatic t_read;
      slvData = 8'hA5;
      step(1, 0, 0, 8'h08);
      check("ctrl bits", {startRequest, ackEnable, interfaceEnable}, 3'b101);
      load(8'hC9);
      step(0, 0, 0, 8'h40);
      step(0, 0, 1, 8'h50);
      check("rx byte", shiftDataReg, 8'hA5);
      check("ack", mstAck, 1);
      check("ack bit", ackEnable, 1);
      slvData = 8'hC3;
      step(0, 0, 0, 8'h58);
      check("rx byte", shiftDataReg, 8'hC3);
      check("ack", mstAck, 0);
      ctl(0, 0, 0);
      check("held", stepDoneFlag, 1);
      end_stop;
      $display("test read done");
   endtask
   task automatic t_nack;
      step(1, 0, 0, 8'h08);
      load(8'hA1);
      step(0, 0, 0, 8'h48);
      ctl(0, 0, 0);
      check("held", stepDoneFlag, 1);
      step(1, 1, 0, 8'h08);
      check("stop bit", stopRequest, 0);
      load(8'hA1);
      step(0, 0, 0, 8'h48);
      step(1, 0, 0, 8'h10);
      load(8'hC8);
      step(0, 0, 0, 8'h18);
      load(8'h33);
      step(0, 0, 0, 8'h28);
      end_stop;
      $display("test nack done");
   endtask
   task automatic t_arb;
      step(1, 0, 0, 8'h08);
      load(8'hC9);
      rivalLow = 1'b1;
      step(0, 0, 0, 8'h38);
      ctl(1, 0, 0);
      repeat (300) @(negedge clk);
      check("waiting", {stepDoneFlag, sdaOe}, 0);
      rivalLow = 1'b0;
      wait_st(8'h08);
      load(8'hC9);
      rivalLow = 1'b1;
      step(0, 0, 0, 8'h38);
      ctl(0, 0, 0);
      repeat (300) @(negedge clk);
      check("released", {stepDoneFlag, sclOe, sdaOe}, 0);
      rivalLow = 1'b0;
      repeat (300) @(negedge clk);
      $display("test arbitration done");
   endtask
   task automatic t_err;
      step(1, 0, 0, 8'h08);
      load(8'hC9);
      ctl(0, 0, 0);
      @(posedge scl);
      repeat (10) @(negedge clk);
      rivalLow = 1'b1;
      wait_st(8'h00);
      check("freed", {sclOe, sdaOe}, 0);
      rivalLow = 1'b0;
      ctl(1, 0, 0);
      check("held", stepDoneFlag, 1);
      ctl(0, 1, 0);
      repeat (300) @(negedge clk);
      check("quiet", {stepDoneFlag, stopRequest, sclOe, sdaOe}, 0);
      $display("test bus error done");
   endtask
   task automatic final_report;
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   initial begin
      repeat (16) @(negedge clk);
      reset = 1'b0;
      t_reset;
      t_read;
      t_nack;
      t_arb;
      t_err;
      final_report;
   end
endmodule // twmrs_sequencer_tb
